// ---- logic/sar_consts.vh ----
// constants for the converter control and serial readout block
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH
// clock and timing
`define CLK_PERIOD_PS   4000
`define T_CONV_NS       290
`define T_EARLY_ACQ_NS  100
`define CONV_CYC        ((`T_CONV_NS * 1000) / `CLK_PERIOD_PS)
`define EARLY_ACQ_CYC   ((`T_EARLY_ACQ_NS * 1000) / `CLK_PERIOD_PS)
`define ACQ_AT_CYC      (`CONV_CYC - `EARLY_ACQ_CYC)
// frame sizes
`define DATA_BITS       16
`define STATUS_BITS     6
`define FRAME_BITS      22
`define CMD_BITS        16
// serial instruction codes (upper byte)
`define CMD_WRITE       8'h14
`define CMD_READ        8'h54
// configuration register fields and reset value
`define CFG_OV          0
`define CFG_TURBO       1
`define CFG_LOWKICK     2
`define CFG_SPAN        3
`define CFG_STATUS      4
`define CFG_WR_MASK     8'h1E
`define CFG_RESET       8'h01
// apb offsets
`define OFS_CONFIG      12'h000
`define OFS_CONTROL     12'h004
`define OFS_RESULT      12'h008
`define OFS_STATE       12'h00C
`define OFS_IRQ_STATUS  12'h010
`define OFS_IRQ_MASK    12'h014
// control register fields
`define CTL_FOUR_WIRE   0
`define CTL_BUSY_EN     1
`define CTL_DAISY       2
`define CTL_RESET       3'h0
// interrupt events
`define IRQ_CONV_DONE   0
`define IRQ_FRAME_DONE  1
`define IRQ_OV          2
`define IRQ_BITS        3
`endif

// ---- logic/pin_sync.v ----
// two flip-flop synchroniser for a group of outside levels
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pin_sync

// ---- logic/sar_adc_serial_readout.v ----
// conversion control, serial readout and apb registers of a 16-bit sar converter
// Overview of operation
// - low-kickback mode off until configured
// - conversion finishes 290 ns after start
// - acquisition resumes 100 ns before conversion ends
// - conversion circuitry powers down after conversion
// - three-wire: convert_start also frames readout
// - four-wire: data input frames readout
// - optional busy indication on data output
// - fast readout allows shifting during conversion
// - fast readout disables busy indication
// - full rate needs fast readout, fast clock
// - status bits follow last data bit
// - daisy chain passes data input through
// - power-up output low unless both inputs high
// - rising convert_start samples and starts conversion
// - 16-bit serial instructions access configuration byte
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "sar_consts.vh"
module sar_adc_serial_readout (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // serial link pins
  input  wire        convert_start,
  input  wire        sclk,
  input  wire        sdi,
  output reg         sdo_out,
  output reg         sdo_oe,
  // analog side
  input  wire [15:0] sample_code,
  input  wire        ov_event,
  output wire        acquiring,
  output wire        conv_powered,
  output wire        low_kickback_en,
  output wire        span_compress_en,
  // interrupt
  output wire        irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // synchronised pins: {ov, sdi, sclk, convert_start}
  wire [3:0] pins_s;
  pin_sync #(.WIDTH(4)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({ov_event, sdi, sclk, convert_start}),
    .sync_out (pins_s)
  );
  wire cnv_s  = pins_s[0];
  wire sclk_s = pins_s[1];
  wire sdi_s  = pins_s[2];
  wire ov_s   = pins_s[3];

  reg        cnv_d;
  reg        sclk_d;
  reg        cs_d;
  reg        state;
  reg  [6:0] conv_cnt;
  reg  [15:0] result;
  reg  [15:0] held_code;
  reg  [7:0] cfg;
  reg  [2:0] ctl;
  reg  [2:0] irq_status;
  reg  [2:0] irq_mask;
  reg        powerup;
  reg  [21:0] shift;
  reg  [4:0] bit_cnt;
  reg  [15:0] cmd_shift;
  reg        read_pending;
  reg        load_pending;
  reg        sdi_bit;

  // edge finding on synchronised copies
  wire cnv_rise  = cnv_s & ~cnv_d;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;

  wire turbo     = cfg[`CFG_TURBO];
  wire four_wire = ctl[`CTL_FOUR_WIRE];
  wire busy_on   = ctl[`CTL_BUSY_EN] & ~turbo;
  wire daisy     = ctl[`CTL_DAISY];

  // frame select: convert_start low in three-wire, sdi low in four-wire
  wire cs_act  = four_wire ? ~sdi_s : ~cnv_s;
  wire cs_fall = cs_act & ~cs_d;
  wire cs_rise = ~cs_act & cs_d;

  wire conv_start = cnv_rise & (state == ST_IDLE);
  wire conv_done  = (state == ST_CONV) && (conv_cnt == `CONV_CYC - 1);
  wire [4:0] frame_len = cfg[`CFG_STATUS] ? 5'd`FRAME_BITS : 5'd`DATA_BITS;

  // apb decode
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire mapped = (paddr <= `OFS_IRQ_MASK) && (paddr[1:0] == 2'b00);

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // conversion timing and power state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      conv_cnt  <= 7'h00;
      held_code <= 16'h0000;
      result    <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (conv_start) begin
            state     <= ST_CONV;
            conv_cnt  <= 7'h00;
            held_code <= sample_code;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state  <= ST_IDLE;
            result <= held_code;
          end else begin
            conv_cnt <= conv_cnt + 7'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign conv_powered = (state == ST_CONV);
  assign acquiring    = (state == ST_IDLE) || (conv_cnt >= `ACQ_AT_CYC);

  // edge history registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnv_d  <= 1'b0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1; // matches cs_act out of reset, so no false select edge
    end else begin
      cnv_d  <= cnv_s;
      sclk_d <= sclk_s;
      cs_d   <= cs_act;
    end
  end

  // power-up output state held until the first conversion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerup <= 1'b1;
    end else if (conv_start) begin
      powerup <= 1'b0;
    end
  end

  // status bits appended after the code
  function [21:0] frame_word;
    input [15:0] code;
    input [7:0]  c;
    begin
      frame_word = {code, c[`CFG_OV], c[`CFG_STATUS], c[`CFG_SPAN], c[`CFG_LOWKICK], c[`CFG_TURBO], 1'b0};
    end
  endfunction

  // serial shifter: load on select, shift after falling clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift        <= 22'h000000;
      bit_cnt      <= 5'h00;
      load_pending <= 1'b0;
      sdi_bit      <= 1'b0;
    end else begin
      if (sclk_rise && cs_act) begin
        sdi_bit <= sdi_s;
      end
      if (cs_fall || (load_pending && conv_done)) begin
        bit_cnt <= 5'h00;
        if (read_pending) begin
          shift        <= {cfg, 14'h0000};
          load_pending <= 1'b0;
        end else if ((state == ST_CONV) && !turbo && !conv_done) begin
          load_pending <= 1'b1; // result not ready yet
        end else begin
          shift        <= frame_word(conv_done ? held_code : result, cfg);
          load_pending <= 1'b0;
        end
      end else if (cs_rise) begin
        load_pending <= 1'b0;
      end else if (sclk_fall && cs_act && !load_pending) begin
        if (cfg[`CFG_STATUS]) begin
          shift <= {shift[20:0], daisy ? sdi_bit : 1'b0};
        end else begin
          // without status bits, chained bits enter right behind the code
          shift <= {shift[20:`STATUS_BITS], daisy ? sdi_bit : 1'b0, {`STATUS_BITS{1'b0}}};
        end
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // data output drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b1;
    end else if (powerup) begin
      sdo_out <= 1'b0;
      sdo_oe  <= ~(cnv_s & sdi_s);
    end else if (!cs_act) begin
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
    end else if (busy_on && ((state == ST_CONV) || load_pending)) begin
      sdo_out <= (state == ST_CONV); // falls low when result ready
      sdo_oe  <= 1'b1;
    end else begin
      sdo_out <= (daisy || bit_cnt < frame_len) ? shift[21] : 1'b0;
      sdo_oe  <= 1'b1;
    end
  end

  // serial instruction receiver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_shift <= 16'h0000;
    end else if (cs_fall) begin
      cmd_shift <= 16'h0000;
    end else if (sclk_rise && cs_act) begin
      cmd_shift <= {cmd_shift[14:0], sdi_s};
    end
  end

  wire cmd_full = cs_rise && (bit_cnt >= `CMD_BITS);
  wire ser_wr   = cmd_full && (cmd_shift[15:8] == `CMD_WRITE);
  wire ser_rd   = cmd_full && (cmd_shift[15:8] == `CMD_READ);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_pending <= 1'b0;
    end else if (ser_rd) begin
      read_pending <= 1'b1;
    end else if (cs_fall) begin
      read_pending <= 1'b0;
    end
  end

  // configuration register; overvoltage flag low while sticky
  wire cfg_read = (rd && (paddr == `OFS_CONFIG)) || (cs_fall && read_pending);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `CFG_RESET;
    end else begin
      if (wr && (paddr == `OFS_CONFIG)) begin
        cfg[4:1] <= pwdata[4:1];
      end else if (ser_wr) begin
        cfg[4:1] <= cmd_shift[4:1];
      end
      if (ov_s) begin
        cfg[`CFG_OV] <= 1'b0; // event wins over clearing read
      end else if (cfg_read) begin
        cfg[`CFG_OV] <= 1'b1;
      end
    end
  end

  assign low_kickback_en  = cfg[`CFG_LOWKICK];
  assign span_compress_en = cfg[`CFG_SPAN];

  // control, interrupt status and mask
  wire [2:0] events = {ov_s, cs_rise, conv_done};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl        <= `CTL_RESET;
      irq_status <= 3'h0;
      irq_mask   <= 3'h0;
    end else begin
      if (wr && (paddr == `OFS_CONTROL)) begin
        ctl <= pwdata[2:0];
      end
      if (wr && (paddr == `OFS_IRQ_MASK)) begin
        irq_mask <= pwdata[2:0];
      end
      if (wr && (paddr == `OFS_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~pwdata[2:0]) | events; // set wins
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_CONFIG:     prdata <= {24'h000000, 3'h0, cfg[4:0]};
        `OFS_CONTROL:    prdata <= {29'h00000000, ctl};
        `OFS_RESULT:     prdata <= {16'h0000, result};
        `OFS_STATE:      prdata <= {28'h0000000, cs_act, powerup, acquiring, conv_powered};
        `OFS_IRQ_STATUS: prdata <= {29'h00000000, irq_status};
        `OFS_IRQ_MASK:   prdata <= {29'h00000000, irq_mask};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // sar_adc_serial_readout

// ---- tb/sar_adc_serial_readout_properties.sv ----
// checker for conversion timing, configuration writes and power-up output
`timescale 1ns/1ps
`include "sar_consts.vh"
module sar_checker (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // link and analog side
  input wire        convert_start,
  input wire        sdi,
  input wire        sdo_out,
  input wire        sdo_oe,
  input wire        acquiring,
  input wire        conv_powered,
  input wire        low_kickback_en,
  input wire        span_compress_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg  [7:0] conv_cnt;
  wire       cfg_wr = psel && penable && pwrite && paddr == `OFS_CONFIG;
  // cycles spent with conversion circuitry on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) conv_cnt <= 8'h00;
    else conv_cnt <= conv_powered ? conv_cnt + 8'h01 : 8'h00;
  end
  conv_time_a: assert property ($fell(conv_powered) |-> conv_cnt == 8'h48)
    else $error("conversion length wrong");
  early_acq_a: assert property ($fell(acquiring) |-> ##[46:48] ($rose(acquiring) && conv_powered))
    else $error("acquisition not resumed early");
  power_down_a: assert property ($rose(conv_powered) |-> ##[71:73] !conv_powered)
    else $error("conversion circuitry left on");
  start_edge_a: assert property ($rose(convert_start) && !conv_powered && acquiring |-> ##[2:4] conv_powered)
    else $error("rising start did not convert");
  lowkick_reset_a: assert property ($rose(presetn) |-> !low_kickback_en && !span_compress_en)
    else $error("feature enabled out of reset");
  cfg_write_a: assert property (cfg_wr |=> low_kickback_en == $past(pwdata[2]) && span_compress_en == $past(pwdata[3]))
    else $error("config write not applied");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr && pready)
    else $error("unmapped access not refused");
  powerup_low_a: assert property ($rose(presetn) |-> (!sdo_out && (sdo_oe || (convert_start && sdi)))[*3])
    else $error("power-up output wrong");
  // main scenarios
  conv_c: cover property ($fell(conv_powered));
  err_c: cover property (pslverr);
  shift_c: cover property (sdo_oe && !conv_powered && !convert_start);
endmodule // sar_checker
bind sar_adc_serial_readout sar_checker i_chk (.*);

// ---- tb/serial_host.sv ----
// host side of the serial link: convert start, select and mode-0 clocking
`timescale 1ns/1ps
module serial_host (
  // from the converter
  input  wire pclk,
  input  wire sdo_out,
  input  wire sdo_oe,
  // to the converter
  output reg  sclk,
  output reg  convert_start,
  output reg  sdi
);
  reg  last;
  wire line = sdo_oe ? sdo_out : ~last;
  // a released data line shows the inverse of its last driven level
  always @(posedge pclk) begin
    if (sdo_oe) last <= sdo_out;
  end
  // link clock idles low between frames
  initial begin
    sclk = 1'b0;
    convert_start = 1'b0;
    sdi = 1'b1;
  end
  // set start and select levels after a clock edge
  task pin(input c, input d);
    begin
      @(posedge pclk);
      convert_start <= c;
      sdi <= d;
    end
  endtask
  // mode-0 frame: sdi changes while clock low, sdo taken on rising clock
  task frame(input integer n, input [31:0] din, output [31:0] dout);
    integer i;
    begin
      dout = 32'h0;
      #37;
      for (i = 0; i < n; i = i + 1) begin
        sdi = din[31-i];
        #80 sclk = 1'b1;
        dout = {dout[30:0], line};
        #80 sclk = 1'b0;
      end
    end
  endtask
endmodule // serial_host

// ---- tb/testbench.sv ----
// self-checking bench for the converter control and serial readout block
`timescale 1ns/1ps
`include "sar_consts.vh"
module testbench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [15:0] sample_code = 16'h0000;
  reg         ov_event = 1'b0;
  reg  [31:0] rd;
  reg  [31:0] sh;
  reg         er;
  wire [31:0] prdata;
  wire        pready, pslverr, sclk, convert_start, sdi, sdo_out, sdo_oe;
  wire        acquiring, conv_powered, low_kickback_en, span_compress_en, irq;
  integer     mismatches = 0;
  integer     n_compared = 0;
  integer     k;
  sar_adc_serial_readout i_sar_adc_serial_readout (.*);
  serial_host i_serial_host (.*);
  // 250 MHz clock
  always #2 pclk = ~pclk;
  task check(input [31:0] seen, input [31:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // apb transfer held until pready is seen
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin n = n + 1; @(posedge pclk); end
      if (n == 50) begin mismatches = mismatches + 1; close_out; end
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  // count cycles of one conversion, bounded
  task conv(output integer n);
    integer t;
    begin
      n = 0; t = 0;
      while (conv_powered !== 1'b1 && t < 10) begin t = t + 1; @(negedge pclk); end
      while (conv_powered === 1'b1 && n < 200) begin n = n + 1; @(negedge pclk); end
      if (t == 10 || n == 200) begin mismatches = mismatches + 1; close_out; end
    end
  endtask
  task t_regs;
    begin
      apb(0, `OFS_CONFIG, 0); check(rd, 32'h1);
      check({sdo_oe, sdo_out}, 2'b10);
      apb(1, `OFS_CONFIG, 32'h0C); @(negedge pclk); check({low_kickback_en, span_compress_en}, 2'b11);
      apb(1, `OFS_CONFIG, 0); apb(0, 12'h040, 0); check(er, 1'b1); check(rd, 32'h0);
    end
  endtask
  task t_conv3;
    begin
      apb(1, `OFS_IRQ_MASK, 32'h1); sample_code <= 16'hA5C3;
      i_serial_host.pin(1, 1); conv(k); check(k, 32'h48);
      check({acquiring, sdo_oe}, 2'b10);
      i_serial_host.pin(0, 1); i_serial_host.frame(16, 32'hFFFFFFFF, sh); check(sh, 32'hA5C3);
      apb(0, `OFS_RESULT, 0); check(irq, 1'b1); check(rd, 32'hA5C3);
      apb(1, `OFS_IRQ_STATUS, 32'h3); @(negedge pclk); check(irq, 0); apb(1, `OFS_IRQ_MASK, 0);
    end
  endtask
  task t_busy;
    begin
      apb(1, `OFS_CONTROL, 32'h2); sample_code <= 16'h7FFF;
      i_serial_host.pin(1, 1); repeat (6) @(posedge pclk); i_serial_host.pin(0, 1);
      repeat (6) @(negedge pclk); check({conv_powered, sdo_oe, sdo_out}, 3'b111);
      conv(k); repeat (3) @(negedge pclk); check({sdo_oe, sdo_out}, 2'b10);
    end
  endtask
  task t_turbo;
    begin
      apb(1, `OFS_CONFIG, 32'h12); sample_code <= 16'h3C5A;
      i_serial_host.pin(1, 1); conv(k); sample_code <= 16'hFFFF;
      i_serial_host.pin(0, 1); i_serial_host.pin(1, 1); repeat (5) @(posedge pclk); i_serial_host.pin(0, 1);
      i_serial_host.frame(22, 32'hFFFFFFFF, sh); check(sh, 32'h000F16B2);
    end
  endtask
  task t_daisy;
    begin
      apb(1, `OFS_CONFIG, 0); apb(1, `OFS_CONTROL, 32'h4); sample_code <= 16'h9C31;
      i_serial_host.pin(1, 1); conv(k); i_serial_host.pin(0, 1);
      i_serial_host.frame(32, 32'h3C960000, sh); check(sh, 32'h9C313C96);
    end
  endtask
  task t_four;
    begin
      apb(1, `OFS_CONTROL, 32'h1); sample_code <= 16'h6E17;
      i_serial_host.pin(1, 1); conv(k); i_serial_host.pin(0, 1);
      repeat (6) @(negedge pclk); check(sdo_oe, 0);
      i_serial_host.pin(0, 0); i_serial_host.frame(16, 0, sh); check(sh, 32'h6E17);
      i_serial_host.pin(0, 1);
    end
  endtask
  // overvoltage flag: low while present, sticky until read after it ends
  task t_ov;
    begin
      ov_event <= 1'b1; repeat (4) @(posedge pclk);
      apb(0, `OFS_CONFIG, 0); check(rd[0], 1'b0);
      ov_event <= 1'b0; repeat (4) @(posedge pclk);
      apb(0, `OFS_CONFIG, 0); check(rd[0], 1'b0);
      apb(0, `OFS_CONFIG, 0); check(rd[0], 1'b1);
      apb(0, `OFS_IRQ_STATUS, 0); check(rd[2], 1'b1);
    end
  endtask
  // serial write then serial read of the configuration byte, three-wire
  task t_cmd;
    begin
      apb(1, `OFS_CONTROL, 0); i_serial_host.frame(16, 32'h14040000, sh); check(sh, 32'h6E17);
      i_serial_host.pin(1, 1); conv(k); check(low_kickback_en, 1'b1);
      i_serial_host.pin(0, 1); i_serial_host.frame(16, 32'h54000000, sh); check(sh, 32'h6E17);
      i_serial_host.pin(1, 1); conv(k); i_serial_host.pin(0, 1);
      i_serial_host.frame(8, 0, sh); check(sh, 32'h05);
    end
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs; t_conv3; t_busy; t_turbo; t_daisy; t_four; t_ov; t_cmd;
    close_out;
  end
endmodule // testbench
